//--- design/psalu_consts.vh
// Opcode and field constants for the packed shift, subtract and unpack ALU.
// Included by the datapath; definitions only.
`ifndef PSALU_CONSTS_VH
`define PSALU_CONSTS_VH
`define PSALU_OP_SRA_D 16'h0fe2
`define PSALU_OP_SRA_W 16'h0fe1
`define PSALU_OP_SRL_Q 16'h0fd3
`define PSALU_OP_SRL_W 16'h0fd1
`define PSALU_OP_SRL_D 16'h0fd2
`define PSALU_OP_IMM_D 16'h0f72
`define PSALU_OP_IMM_W 16'h0f71
`define PSALU_OP_IMM_Q 16'h0f73
`define PSALU_REG_SRA 3'h4
`define PSALU_REG_SRL 3'h2
`define PSALU_OP_SUB_B 16'h0ff8
`define PSALU_OP_SUB_W 16'h0ff9
`define PSALU_OP_SUB_D 16'h0ffa
`define PSALU_OP_SUBS_B 16'h0fe8
`define PSALU_OP_SUBS_W 16'h0fe9
`define PSALU_OP_SUBUS_B 16'h0fd8
`define PSALU_OP_SUBUS_W 16'h0fd9
`define PSALU_OP_UNPH_B 16'h0f68
`define PSALU_OP_UNPH_W 16'h0f69
`define PSALU_OP_UNPH_D 16'h0f6a
`define PSALU_OP_UNPL_B 16'h0f60
`define PSALU_OP_UNPL_W 16'h0f61
`define PSALU_OP_UNPL_D 16'h0f62
`define PSALU_OP_XOR 16'h0fef
`define PSALU_RST_DATA 64'h0
`define PSALU_LATENCY 1
`endif

//--- design/psalu_top.v
// Packed shift/subtract/unpack/xor datapath, one-clock latency.
// Assumes the issue stage presents decoded opcode, reg field, operands and
// an immediate count from the same clock; a new op may issue each cycle.
//
// Operation
// (RULE_01) Arithmetic right shift of dword lanes
// (RULE_02) Arithmetic right shift of word lanes
// (RULE_03) Logical right shift dword lanes, one clock
// (RULE_04) Logical right shift of whole qword
// (RULE_05) Logical right shift of word lanes
// (RULE_06) Count from register, memory or immediate
// (RULE_07) Byte subtract wrapping modulo 256
// (RULE_08) Dword subtract keeping low 32 bits
// (RULE_09) Word subtract keeping low 16 bits
// (RULE_10) Signed byte subtract with clamping
// (RULE_11) Signed word subtract with clamping
// (RULE_12) Unsigned byte/word subtract clamped at zero
// (RULE_13) Interleave upper half byte/word/dword lanes
// (RULE_14) Interleave lower half byte/word/dword lanes
// (RULE_15) Qword exclusive-or, one clock
// (RULE_16) Oversize counts zero or sign-fill lanes
// (RULE_17) Clamp ranges signed and unsigned
`timescale 1ns/1ps
`default_nettype none
`include "psalu_consts.vh"

module psalu_top (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Issue
  input wire issue_valid,
  input wire [15:0] opcode,
  input wire [2:0] reg_field,
  input wire imm_form,
  input wire [7:0] imm_count,
  // Operands
  input wire [63:0] dest_packed_reg,
  input wire [63:0] src_packed_reg,
  // Result
  output reg result_valid_r,
  output reg [63:0] result_r,
  output reg unknown_op_r
);

  // ==========================================================
  // Count selection, lane shifts and lane subtracts
  reg [63:0] count;
  reg [63:0] sh_d;
  reg [63:0] sh_w;
  reg [63:0] sh_q;
  reg [63:0] res_nxt;
  reg known_nxt;
  reg [63:0] sub_b;
  reg [63:0] sub_w;
  reg [63:0] sub_d;
  reg [63:0] sat_sb;
  reg [63:0] sat_sw;
  reg [63:0] sat_ub;
  reg [63:0] sat_uw;
  reg [8:0] db;
  reg [16:0] dw;
  reg [31:0] dd;
  // Signed lane temporaries keep the shift arithmetic
  reg signed [15:0] lane_w;
  reg signed [31:0] lane_d;
  integer i;

  wire big_d = |count[63:5];
  wire big_w = |count[63:4];
  wire big_q = |count[63:6];

  always @* begin
    // Immediate byte or full 64-bit register/memory count
    count = imm_form ? {56'h0, imm_count} : src_packed_reg; // RULE_06
    sh_q = big_q ? 64'h0 : (dest_packed_reg >> count[5:0]); // RULE_04 RULE_16
    sh_d = 64'h0;
    sh_w = 64'h0;
    sub_b = 64'h0;
    sub_w = 64'h0;
    sub_d = 64'h0;
    sat_sb = 64'h0;
    sat_sw = 64'h0;
    sat_ub = 64'h0;
    sat_uw = 64'h0;
    db = 9'h0;
    dw = 17'h0;
    dd = 32'h0;
    lane_w = 16'h0;
    lane_d = 32'h0;
    for (i = 0; i < 8; i = i + 1) begin
      db = {dest_packed_reg[i*8+7], dest_packed_reg[i*8 +: 8]} -
           {src_packed_reg[i*8+7], src_packed_reg[i*8 +: 8]};
      sub_b[i*8 +: 8] = db[7:0]; // RULE_07
      if (db[8] != db[7])
        sat_sb[i*8 +: 8] = db[8] ? 8'h80 : 8'h7f; // RULE_10 RULE_17
      else
        sat_sb[i*8 +: 8] = db[7:0];
      db = {1'b0, dest_packed_reg[i*8 +: 8]} -
           {1'b0, src_packed_reg[i*8 +: 8]};
      sat_ub[i*8 +: 8] = db[8] ? 8'h00 : db[7:0]; // RULE_12 RULE_17
    end
    for (i = 0; i < 4; i = i + 1) begin
      lane_w = dest_packed_reg[i*16 +: 16];
      lane_w = lane_w >>> count[3:0];
      sh_w[i*16 +: 16] = big_w ? {16{dest_packed_reg[i*16+15]}} : lane_w;
      dw = {dest_packed_reg[i*16+15], dest_packed_reg[i*16 +: 16]} -
           {src_packed_reg[i*16+15], src_packed_reg[i*16 +: 16]};
      sub_w[i*16 +: 16] = dw[15:0]; // RULE_09
      if (dw[16] != dw[15])
        sat_sw[i*16 +: 16] = dw[16] ? 16'h8000 : 16'h7fff; // RULE_11 RULE_17
      else
        sat_sw[i*16 +: 16] = dw[15:0];
      dw = {1'b0, dest_packed_reg[i*16 +: 16]} -
           {1'b0, src_packed_reg[i*16 +: 16]};
      sat_uw[i*16 +: 16] = dw[16] ? 16'h0000 : dw[15:0]; // RULE_12
    end
    for (i = 0; i < 2; i = i + 1) begin
      lane_d = dest_packed_reg[i*32 +: 32];
      lane_d = lane_d >>> count[4:0];
      sh_d[i*32 +: 32] = big_d ? {32{dest_packed_reg[i*32+31]}} : lane_d;
      dd = dest_packed_reg[i*32 +: 32] - src_packed_reg[i*32 +: 32];
      sub_d[i*32 +: 32] = dd[31:0]; // RULE_08
    end
  end

  // ==========================================================
  // Logical lane shifts
  function [63:0] srl_lanes;
    input [63:0] v;
    input [63:0] c;
    input wide;
    integer k;
    begin
      srl_lanes = 64'h0;
      if (wide) begin
        for (k = 0; k < 2; k = k + 1)
          srl_lanes[k*32 +: 32] = (|c[63:5]) ? 32'h0 :
            (v[k*32 +: 32] >> c[4:0]);
      end else begin
        for (k = 0; k < 4; k = k + 1)
          srl_lanes[k*16 +: 16] = (|c[63:4]) ? 16'h0 :
            (v[k*16 +: 16] >> c[3:0]);
      end
    end
  endfunction

  // ==========================================================
  // Interleave
  function [63:0] unpack;
    input [63:0] d;
    input [63:0] s;
    input hi;
    input [1:0] sz;
    integer k;
    begin
      unpack = 64'h0;
      case (sz)
        2'h0: begin
          for (k = 0; k < 4; k = k + 1)
            unpack[k*16 +: 16] = hi ? {s[32+k*8 +: 8], d[32+k*8 +: 8]} :
              {s[k*8 +: 8], d[k*8 +: 8]};
        end
        2'h1: begin
          for (k = 0; k < 2; k = k + 1)
            unpack[k*32 +: 32] = hi ? {s[32+k*16 +: 16], d[32+k*16 +: 16]} :
              {s[k*16 +: 16], d[k*16 +: 16]};
        end
        default: begin
          unpack = hi ? {s[63:32], d[63:32]} : {s[31:0], d[31:0]};
        end
      endcase
    end
  endfunction

  // ==========================================================
  // Opcode decode
  always @* begin
    known_nxt = 1'b1;
    res_nxt = `PSALU_RST_DATA;
    case (opcode)
      `PSALU_OP_SRA_D: res_nxt = sh_d; // RULE_01
      `PSALU_OP_SRA_W: res_nxt = sh_w; // RULE_02
      `PSALU_OP_SRL_D: res_nxt = srl_lanes(dest_packed_reg, count, 1'b1); // RULE_03
      `PSALU_OP_SRL_Q: res_nxt = sh_q; // RULE_04
      `PSALU_OP_SRL_W: res_nxt = srl_lanes(dest_packed_reg, count, 1'b0); // RULE_05
      `PSALU_OP_IMM_D: begin
        if (reg_field == `PSALU_REG_SRA)
          res_nxt = sh_d; // RULE_01
        else if (reg_field == `PSALU_REG_SRL)
          res_nxt = srl_lanes(dest_packed_reg, count, 1'b1); // RULE_03
        else
          known_nxt = 1'b0;
      end
      `PSALU_OP_IMM_W: begin
        if (reg_field == `PSALU_REG_SRA)
          res_nxt = sh_w; // RULE_02
        else if (reg_field == `PSALU_REG_SRL)
          res_nxt = srl_lanes(dest_packed_reg, count, 1'b0); // RULE_05
        else
          known_nxt = 1'b0;
      end
      `PSALU_OP_IMM_Q: begin
        if (reg_field == `PSALU_REG_SRL)
          res_nxt = sh_q; // RULE_04
        else
          known_nxt = 1'b0;
      end
      `PSALU_OP_SUB_B: res_nxt = sub_b; // RULE_07
      `PSALU_OP_SUB_W: res_nxt = sub_w; // RULE_09
      `PSALU_OP_SUB_D: res_nxt = sub_d; // RULE_08
      `PSALU_OP_SUBS_B: res_nxt = sat_sb; // RULE_10
      `PSALU_OP_SUBS_W: res_nxt = sat_sw; // RULE_11
      `PSALU_OP_SUBUS_B: res_nxt = sat_ub; // RULE_12
      `PSALU_OP_SUBUS_W: res_nxt = sat_uw; // RULE_12
      `PSALU_OP_UNPH_B: res_nxt = unpack(dest_packed_reg, src_packed_reg, 1'b1, 2'h0); // RULE_13
      `PSALU_OP_UNPH_W: res_nxt = unpack(dest_packed_reg, src_packed_reg, 1'b1, 2'h1); // RULE_13
      `PSALU_OP_UNPH_D: res_nxt = unpack(dest_packed_reg, src_packed_reg, 1'b1, 2'h2); // RULE_13
      `PSALU_OP_UNPL_B: res_nxt = unpack(dest_packed_reg, src_packed_reg, 1'b0, 2'h0); // RULE_14
      `PSALU_OP_UNPL_W: res_nxt = unpack(dest_packed_reg, src_packed_reg, 1'b0, 2'h1); // RULE_14
      `PSALU_OP_UNPL_D: res_nxt = unpack(dest_packed_reg, src_packed_reg, 1'b0, 2'h2); // RULE_14
      `PSALU_OP_XOR: res_nxt = dest_packed_reg ^ src_packed_reg; // RULE_15
      default: known_nxt = 1'b0;
    endcase
  end

  // ==========================================================
  // Result register, one op per clock
  always @(posedge sys_clk) begin
    if (rst) begin
      result_valid_r <= 1'b0;
      result_r <= `PSALU_RST_DATA;
      unknown_op_r <= 1'b0;
    end else begin
      result_valid_r <= issue_valid & known_nxt; // RULE_03 RULE_06 RULE_15
      unknown_op_r <= issue_valid & ~known_nxt;
      if (issue_valid & known_nxt)
        result_r <= res_nxt;
    end
  end

endmodule

`default_nettype wire

//--- verif/psalu_props.sv
// Checker for the packed ALU, bound onto psalu_top.
// Sees only the top ports; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module psalu_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Issue and operands
  input wire logic issue_valid,
  input wire logic [15:0] opcode,
  input wire logic [2:0] reg_field,
  input wire logic imm_form,
  input wire logic [7:0] imm_count,
  input wire logic [63:0] dest_packed_reg,
  input wire logic [63:0] src_packed_reg,
  // Result
  input wire logic result_valid_r,
  input wire logic [63:0] result_r,
  input wire logic unknown_op_r
);
  // ====================
  // Properties
  wire logic [15:0] o = issue_valid ? opcode : 16'h0;
  wire logic [63:0] d = dest_packed_reg;
  wire logic [63:0] s = src_packed_reg;
  wire logic [63:0] q = result_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_xor_one_clock: assert property (o == 16'h0fef |=>
    result_valid_r && q == $past(d ^ s)) else $error("xor result");
  a_srl_qword_reg: assert property (
    o == 16'h0fd3 && !imm_form |=> q == $past(d >> s))
    else $error("qword shift");
  a_srl_qword_imm: assert property (
    o == 16'h0f73 && reg_field == 3'h2 && imm_form |=>
    q == $past(d >> imm_count)) else $error("qword imm shift");
  a_unpack_low: assert property (o == 16'h0f62 |=>
    q == $past({s[31:0], d[31:0]})) else $error("unpack low");
  a_unpack_high: assert property (o == 16'h0f6a |=>
    q == $past({s[63:32], d[63:32]})) else $error("unpack high");
  a_unsigned_floor: assert property (
    o == 16'h0fd8 && d[15:8] < s[15:8] |=> q[15:8] == 8'h00)
    else $error("unsigned clamp");
  a_sign_fill: assert property (
    o == 16'h0fe2 && !imm_form && s > 64'h1f |=>
    q == {{32{$past(d[63])}}, {32{$past(d[31])}}}) else $error("sign fill");
  a_idle_quiet: assert property (!issue_valid |=>
    !result_valid_r && !unknown_op_r && $stable(q)) else $error("idle");
  c_xor: cover property (o == 16'h0fef);
  c_refused: cover property (unknown_op_r);
  c_back_to_back: cover property (result_valid_r ##1 result_valid_r);
endmodule
bind psalu_top psalu_props i_psalu_props (.sys_clk, .rst, .issue_valid,
  .opcode, .reg_field, .imm_form, .imm_count, .dest_packed_reg,
  .src_packed_reg, .result_valid_r, .result_r, .unknown_op_r);
`default_nettype wire

//--- verif/psalu_issue_model.sv
// Issue stage model: presents one op per call just after a clock edge.
// Called from the bench; released operand lines show inverted values.
`timescale 1ns/1ps
`default_nettype none
module psalu_issue_model (
  // Clock
  input wire logic sys_clk,
  // Issue and operands
  output logic issue_valid,
  output logic [15:0] opcode,
  output logic [2:0] reg_field,
  output logic imm_form,
  output logic [7:0] imm_count,
  output logic [63:0] dest_packed_reg,
  output logic [63:0] src_packed_reg
);
  // ====================
  // Drive tasks
  task automatic set(input logic v, input logic [15:0] o,
    input logic [2:0] f, input logic [7:0] c, input logic [63:0] d, s);
    issue_valid = v;
    opcode = o;
    reg_field = f;
    imm_form = f != 3'h0;
    imm_count = c;
    dest_packed_reg = d;
    src_packed_reg = s;
  endtask
  task automatic put(input logic [15:0] o, input logic [2:0] f,
    input logic [7:0] c, input logic [63:0] d, s);
    @(posedge sys_clk);
    #1;
    set(1'b1, o, f, c, d, s);
  endtask
  task automatic idle();
    @(posedge sys_clk);
    #1;
    set(1'b0, ~opcode, ~reg_field, ~imm_count, ~dest_packed_reg,
      ~src_packed_reg);
  endtask
  initial set(1'b0, 16'h0, 3'h0, 8'h0, 64'h0, 64'h0);
endmodule
`default_nettype wire

//--- verif/psalu_top_test.sv
// Bench for the packed ALU, scenarios with hand-worked results.
// Needs psalu_top, psalu_issue_model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) checks++; \
  if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s exp %h saw %h", n, e, g); end
module psalu_top_test;
  localparam logic [63:0] dv = 64'h8877665544332211;
  localparam logic [63:0] sb = 64'h7f8000112299ff01;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  int num_errors = 0;
  int checks = 0;
  wire logic issue_valid, imm_form, result_valid_r, unknown_op_r;
  wire logic [15:0] opcode;
  wire logic [2:0] reg_field;
  wire logic [7:0] imm_count;
  wire logic [63:0] dest_packed_reg, src_packed_reg, result_r;
  psalu_top i_psalu_top (.sys_clk, .rst, .issue_valid, .opcode,
    .reg_field, .imm_form, .imm_count, .dest_packed_reg, .src_packed_reg,
    .result_valid_r, .result_r, .unknown_op_r);
  psalu_issue_model i_psalu_issue_model (.sys_clk, .issue_valid, .opcode,
    .reg_field, .imm_form, .imm_count, .dest_packed_reg, .src_packed_reg);
  always #2.5 sys_clk = ~sys_clk;
  // ====================
  // Scenarios
  task look(input logic [63:0] e);
    `CHK("valid", 1'b1, result_valid_r)
    `CHK("result", e, result_r)
  endtask
  task sh(input logic [15:0] o, input logic [2:0] f, input logic [7:0] c,
    input logic [63:0] e);
    i_psalu_issue_model.put(o, f, c, dv, f != 3'h0 ? sb : {56'h0, c});
    i_psalu_issue_model.idle();
    look(e);
  endtask
  task su(input logic [15:0] o, input logic [63:0] e);
    i_psalu_issue_model.put(o, 3'h0, 8'h0, dv, sb);
    i_psalu_issue_model.idle();
    look(e);
  endtask
  task t_shift();
    sh(16'h0fe2, 3'h0, 8'h04, 64'hf887766504433221);
    sh(16'h0fe2, 3'h0, 8'h20, 64'hffffffff00000000);
    sh(16'h0f72, 3'h4, 8'h08, 64'hff88776600443322);
    sh(16'h0fe1, 3'h0, 8'h04, 64'hf887066504430221);
    sh(16'h0f71, 3'h4, 8'h10, 64'hffff000000000000);
    sh(16'h0fd2, 3'h0, 8'h04, 64'h0887766504433221);
    sh(16'h0f72, 3'h2, 8'h08, 64'h0088776600443322);
    sh(16'h0fd3, 3'h0, 8'h0c, 64'h0008877665544332);
    sh(16'h0f73, 3'h2, 8'h3f, 64'h0000000000000001);
    sh(16'h0fd1, 3'h0, 8'h04, 64'h0887066504430221);
    sh(16'h0f71, 3'h2, 8'h10, 64'h0);
  endtask
  task t_sub();
    su(16'h0ff8, 64'h09f76644229a2310);
    su(16'h0ff9, 64'h08f76644219a2310);
    su(16'h0ffa, 64'h08f7664421992310);
    su(16'h0fe8, 64'h807f6644227f2310);
    su(16'h0fe9, 64'h80006644219a2310);
    su(16'h0fd8, 64'h0900664422000010);
    su(16'h0fd9, 64'h08f76644219a0000);
  endtask
  task t_unpack();
    su(16'h0f60, 64'h22449933ff220111);
    su(16'h0f61, 64'h22994433ff012211);
    su(16'h0f62, 64'h2299ff0144332211);
    su(16'h0f68, 64'h7f88807700661155);
    su(16'h0f69, 64'h7f80887700116655);
    su(16'h0f6a, 64'h7f80001188776655);
  endtask
  task t_b2b();
    i_psalu_issue_model.put(16'h0fd2, 3'h0, 8'h0, dv, 64'h4);
    i_psalu_issue_model.put(16'h0fef, 3'h0, 8'h0, dv, sb);
    look(64'h0887766504433221);
    i_psalu_issue_model.put(16'h0f73, 3'h4, 8'h1, dv, sb);
    look(64'hf7f7664466aadd10);
    i_psalu_issue_model.idle();
    `CHK("refused", 1'b1, unknown_op_r)
    `CHK("held", 64'hf7f7664466aadd10, result_r)
  endtask
  task results();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    t_shift();
    t_sub();
    t_unpack();
    t_b2b();
    results();
  end
  initial begin
    #2000;
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
